// ---- cbcfg_pkg.sv ----
// Purpose: Shared constants for the card bridge configuration header slice
// Assumes: Configuration offsets are byte addresses, accessed as dwords
// Notes:   Dword index is the byte offset shifted right by two
package cbcfg_pkg;
  localparam int CFG_IDX_W = 6;
  localparam logic [7:0] OFF_CACHE_LINE = 8'h0c;
  localparam logic [7:0] OFF_LAT_LIMIT  = 8'h0d;
  localparam logic [7:0] OFF_HDR_TYPE   = 8'h0e;
  localparam logic [7:0] OFF_SELF_TEST  = 8'h0f;
  localparam logic [7:0] OFF_SOCK_BASE  = 8'h10;
  localparam logic [7:0] OFF_CAP_PTR    = 8'h14;
  localparam logic [7:0] OFF_CARD_STAT  = 8'h16;
  localparam logic [7:0] OFF_HDR_LAST   = 8'h7f;
  localparam logic [7:0] OFF_EXT_FIRST  = 8'h80;
  localparam logic [5:0] IDX_MISC       = 6'h03;
  localparam logic [5:0] IDX_BASE       = 6'h04;
  localparam logic [5:0] IDX_CAPSTAT    = 6'h05;
  localparam logic [7:0]  RST_CACHE_LINE = 8'h00;
  localparam logic [7:0]  RST_LAT_LIMIT  = 8'h00;
  localparam logic [7:0]  VAL_HDR_TYPE   = 8'h82;
  localparam logic [7:0]  VAL_SELF_TEST  = 8'h00;
  localparam logic [19:0] RST_SOCK_BASE  = 20'h00000;
  localparam logic [7:0]  VAL_CAP_PTR    = 8'ha0;
  localparam logic [15:0] RST_CARD_STAT  = 16'h0200;
  localparam int BASE_LSB = 12;
  localparam logic [11:0] WIN_LEGACY_OFF = 12'h800;
  localparam int ST_PARITY = 15;
  localparam int ST_SERR   = 14;
  localparam int ST_MABORT = 13;
  localparam int ST_TA_REC = 12;
  localparam int ST_TA_SIG = 11;
  localparam int ST_DPAR   = 8;
  localparam logic [1:0]  VAL_SELECT_TIMING = 2'h1;
  localparam logic [15:0] STAT_CLR_MASK     = 16'hf900;
  localparam logic [7:0]  LAT_MAX           = 8'hff;
endpackage

// ---- cbcfg_lat_timer.sv ----
// Purpose: Initiator latency counter with grant-driven termination
// Assumes: Grant input is already synchronised, active low
// Notes:   Counter saturates so a long burst cannot wrap back under the limit
`timescale 1ns/100ps
module cbcfg_lat_timer
  import cbcfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       frame_start,
  input  wire logic       xfer_done,
  input  wire logic [7:0] limit,
  input  wire logic       gnt_n_sync,
  output logic            expired,
  output logic            end_req
);
  typedef enum logic [2:0] {
    LT_IDLE  = 3'b001,
    LT_COUNT = 3'b010,
    LT_EXPD  = 3'b100
  } cbcfg_lat_state_t;

  cbcfg_lat_state_t state_q;
  cbcfg_lat_state_t state_d;
  logic [7:0]       count_q;
  logic [7:0]       count_d;
  logic             end_d;
  logic             end_q;
  wire              hit_limit = (count_q >= limit);

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    end_d   = 1'b0;
    unique case (state_q)
      LT_IDLE:
      begin
        if (frame_start)
        begin
          count_d = 8'h00;
          state_d = LT_COUNT;
        end
      end
      LT_COUNT:
      begin
        if (xfer_done)
          state_d = LT_IDLE;
        else if (hit_limit)
          state_d = LT_EXPD;
        else if (count_q != LAT_MAX)
          count_d = count_q + 8'h01;
      end
      LT_EXPD:
      begin
        if (xfer_done)
          state_d = LT_IDLE;
        else if (gnt_n_sync)
        begin
          end_d   = 1'b1;
          state_d = LT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= LT_IDLE;
      count_q <= 8'h00;
      end_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      end_q   <= end_d;
    end
  end

  // One-hot expiry bit, so the output comes straight from a flop
  assign expired = state_q[2];
  assign end_req = end_q;

  end_on_gnt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == LT_EXPD && gnt_n_sync && !xfer_done) |=> end_q)
    else $error("Expired timer did not end transfer on grant loss");
  no_early_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_q |-> $past(state_q) == LT_EXPD)
    else $error("Transfer ended before timer expiry");
  count_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == LT_IDLE && frame_start) |=> count_q == 8'h00)
    else $error("Latency count not restarted at frame");
  cover_expiry_c: cover property (@(posedge clk) disable iff (!rst_n) end_q);
endmodule

// ---- cbcfg_header.sv ----
// Purpose: Configuration header slice 0Ch..17h of a card bridge function
// Assumes: Config port and event inputs on core_clk; card pins and grant are async
// Notes:   Config read data is returned one cycle after the request
// Behaviour
// - Cache line size at 0Ch: 8-bit read/write, resets to zero.
// - Latency count restarts at zero on frame start while idle, counts clocks toward 0Dh limit.
// - Expired latency count ends the current transfer once grant is removed.
// - Header type at 0Eh always reads 82h; writes ignored.
// - Offsets to 7Fh form the standard header; 80h..FFh are extension space.
// - Self-test register at 0Fh always reads zero.
// - Socket base at 10h: bits 31..12 writable, bits 11..0 read zero.
// - Writing all ones to socket base reads back FFFFF000h.
// - Socket window maps socket registers at 000h, legacy registers at 800h.
// - Capability pointer at 14h reads A0h.
// - Card status flags clear only on write-one; register resets to 0200h.
// - Bit 15 sets on card-side address or data parity error.
// - Bit 14 sets when a card signals system error; never driven here.
// - Bit 13 sets when own card cycle ends in master abort.
// - Bit 12 sets when own card cycle is target aborted.
// - Bit 11 sets when this bridge target-aborts a card transaction.
// - Bits 10..9 read fixed 01b, medium select timing.
// - Bit 8 sets on card parity report while master with response enabled.
// - Bits 7, 6 and 5 read zero.
// - Reserved bits 4..0 read zero.
`timescale 1ns/100ps
module cbcfg_header
  import cbcfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_ack,
  output logic             cfg_hdr_hit,
  output logic             cfg_ext_hit,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             sock_reg_hit,
  output logic             legacy_reg_hit,
  input  wire logic        init_frame_start,
  input  wire logic        init_xfer_done,
  input  wire logic        bus_gnt_n,
  output logic             init_lat_expired,
  output logic             init_end_req,
  input  wire logic        card_addr_par_err,
  input  wire logic        card_data_par_err,
  input  wire logic        card_serr_n,
  input  wire logic        card_perr_n,
  input  wire logic        card_master_dphase,
  input  wire logic        parity_resp_en,
  input  wire logic        own_master_abort,
  input  wire logic        own_target_abort_rx,
  input  wire logic        own_target_abort_tx,
  output logic             card_serr_out,
  output logic             card_serr_oe,
  output logic [7:0]       cache_line_size,
  output logic [31:0]      socket_base
);
  logic        rst_meta_q;
  logic        rst_n_q;
  logic [2:0]  pin_meta_q;
  logic [2:0]  pin_sync_q;
  logic [7:0]  cls_q;
  logic [7:0]  lat_q;
  logic [19:0] base_q;
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [31:0] rdata_q;
  logic        ack_q;
  logic        hdr_hit_q;
  logic        ext_hit_q;
  logic        sock_hit_q;
  logic        leg_hit_q;
  logic        serr_drv_q;
  logic        lat_expired;
  logic        lat_end;
  logic [5:0]  rd_idx_q;
  logic        rd_was_q;

  // Reset release through two flops, assert stays asynchronous
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Card pins and grant: only the second stage is used below
  wire [2:0] pin_raw = {bus_gnt_n, card_perr_n, card_serr_n};
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_meta_q <= 3'h7;
      pin_sync_q <= 3'h7;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end
  wire serr_seen = ~pin_sync_q[0];
  wire perr_seen = ~pin_sync_q[1];
  wire gnt_n_s   = pin_sync_q[2];

  // Address decode
  wire [5:0] idx      = cfg_addr[7:2];
  wire       wr       = cfg_req && cfg_we;
  wire       in_hdr   = (cfg_addr <= OFF_HDR_LAST);
  wire       in_ext   = (cfg_addr >= OFF_EXT_FIRST);
  wire       wr_misc  = wr && (idx == IDX_MISC);
  wire       wr_base  = wr && (idx == IDX_BASE);
  wire       wr_stat  = wr && (idx == IDX_CAPSTAT);

  // Per-bit status write-one-to-clear, sets win over clears
  wire [15:0] clr_bits = wr_stat ?
    (cfg_wdata[31:16] & {{8{cfg_be[3]}}, {8{cfg_be[2]}}} & STAT_CLR_MASK) : 16'h0000;
  wire [15:0] set_bits;
  assign set_bits[ST_PARITY] = card_addr_par_err || card_data_par_err;
  assign set_bits[ST_SERR]   = serr_seen;
  assign set_bits[ST_MABORT] = own_master_abort;
  assign set_bits[ST_TA_REC] = own_target_abort_rx;
  assign set_bits[ST_TA_SIG] = own_target_abort_tx;
  assign set_bits[ST_DPAR]   = perr_seen && card_master_dphase && parity_resp_en;
  assign set_bits[10:9]      = 2'h0;
  assign set_bits[7:0]       = 8'h00;

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_stat
      if (STAT_CLR_MASK[g])
      begin : g_flag
        assign stat_d[g] = set_bits[g] | (stat_q[g] & ~clr_bits[g]);
      end
      else
      begin : g_fixed
        assign stat_d[g] = RST_CARD_STAT[g];
      end
    end
  endgenerate

  // Read data assembly
  wire [31:0] rd_misc = {VAL_SELF_TEST, VAL_HDR_TYPE, lat_q, cls_q};
  wire [31:0] rd_base = {base_q, 12'h000};
  wire [31:0] rd_cap  = {stat_q, 8'h00, VAL_CAP_PTR};
  wire [31:0] rd_mux  = (idx == IDX_MISC)    ? rd_misc :
                        (idx == IDX_BASE)    ? rd_base :
                        (idx == IDX_CAPSTAT) ? rd_cap  : 32'h00000000;

  // Socket window decode
  wire win_hit  = mem_req && (mem_addr[31:BASE_LSB] == base_q);
  wire win_leg  = (mem_addr[11:0] >= WIN_LEGACY_OFF);

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cls_q <= RST_CACHE_LINE;
      lat_q <= RST_LAT_LIMIT;
    end
    else if (wr_misc)
    begin
      if (cfg_be[0])
        cls_q <= cfg_wdata[7:0];
      if (cfg_be[1])
        lat_q <= cfg_wdata[15:8];
    end
  end

  // Byte 1 holds only bits 15..12; the low nibble is hardwired zero
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      base_q <= RST_SOCK_BASE;
    else if (wr_base)
    begin
      if (cfg_be[1])
        base_q[3:0] <= cfg_wdata[15:12];
      if (cfg_be[2])
        base_q[11:4] <= cfg_wdata[23:16];
      if (cfg_be[3])
        base_q[19:12] <= cfg_wdata[31:24];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      stat_q <= RST_CARD_STAT;
    else
      stat_q <= stat_d;
  end

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdata_q   <= 32'h00000000;
      ack_q     <= 1'b0;
      hdr_hit_q <= 1'b0;
      ext_hit_q <= 1'b0;
      rd_idx_q  <= 6'h00;
      rd_was_q  <= 1'b0;
    end
    else
    begin
      rdata_q   <= (cfg_req && !cfg_we) ? rd_mux : 32'h00000000;
      ack_q     <= cfg_req;
      hdr_hit_q <= cfg_req && in_hdr;
      ext_hit_q <= cfg_req && in_ext;
      rd_idx_q  <= idx;
      rd_was_q  <= cfg_req && !cfg_we;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sock_hit_q <= 1'b0;
      leg_hit_q  <= 1'b0;
      serr_drv_q <= 1'b0;
    end
    else
    begin
      sock_hit_q <= win_hit && !win_leg;
      leg_hit_q  <= win_hit && win_leg;
      serr_drv_q <= 1'b0;
    end
  end

  cbcfg_lat_timer cbcfg_lat_timer_i (
    .clk         (core_clk),
    .rst_n       (rst_n_q),
    .frame_start (init_frame_start),
    .xfer_done   (init_xfer_done),
    .limit       (lat_q),
    .gnt_n_sync  (gnt_n_s),
    .expired     (lat_expired),
    .end_req     (lat_end)
  );

  // Expiry flag is a state-register decode inside the timer
  assign cfg_rdata        = rdata_q;
  assign cfg_ack          = ack_q;
  assign cfg_hdr_hit      = hdr_hit_q;
  assign cfg_ext_hit      = ext_hit_q;
  assign sock_reg_hit     = sock_hit_q;
  assign legacy_reg_hit   = leg_hit_q;
  assign init_lat_expired = lat_expired;
  assign init_end_req     = lat_end;
  assign card_serr_out    = serr_drv_q;
  assign card_serr_oe     = serr_drv_q;
  assign cache_line_size  = cls_q;
  assign socket_base      = {base_q, 12'h000};

  cls_write_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (wr_misc && cfg_be[0]) |=> cls_q == $past(cfg_wdata[7:0]))
    else $error("Cache line size not written");
  lat_write_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (wr_misc && cfg_be[1]) |=> lat_q == $past(cfg_wdata[15:8]))
    else $error("Latency limit not written");
  misc_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !wr_misc |=> $stable(cls_q) && $stable(lat_q))
    else $error("Byte registers changed without a write");
  hdr_const_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (rd_was_q && rd_idx_q == IDX_MISC) |-> cfg_rdata[31:16] == 16'h0082)
    else $error("Header type or self-test read wrong");
  base_low_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (rd_was_q && rd_idx_q == IDX_BASE) |-> cfg_rdata[11:0] == 12'h000)
    else $error("Socket base low bits not zero");
  base_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !wr_base |=> $stable(socket_base))
    else $error("Socket base changed without a write");
  base_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (wr_base && cfg_be == 4'hf && cfg_wdata == 32'hffffffff) |=> socket_base == 32'hfffff000)
    else $error("All-ones write did not size to 4K");
  cap_ptr_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (rd_was_q && rd_idx_q == IDX_CAPSTAT) |-> cfg_rdata[15:0] == 16'h00a0)
    else $error("Capability pointer read wrong");
  stat_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    stat_q[10:0] == {2'h1, stat_q[8], 8'h00})
    else $error("Fixed status bits changed");
  set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    own_master_abort |=> stat_q[ST_MABORT])
    else $error("Master abort flag lost");
  clear_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (stat_q[ST_TA_SIG] && !(wr_stat && cfg_be[3] && cfg_wdata[27])) |=> stat_q[ST_TA_SIG])
    else $error("Status flag cleared without a one");
  clear_one_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (wr_stat && cfg_be[3] && cfg_wdata[31] && !set_bits[ST_PARITY]) |=> !stat_q[ST_PARITY])
    else $error("Parity flag not cleared by one");
  serr_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    $fell(card_serr_n) |-> ##[3:4] stat_q[ST_SERR])
    else $error("Card system error not recorded");
  serr_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !card_serr_oe)
    else $error("Card system error driven");
  dpar_cond_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    $rose(stat_q[ST_DPAR]) |-> $past(parity_resp_en) && $past(card_master_dphase))
    else $error("Data parity flag set without conditions");
  par_set_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (card_addr_par_err || card_data_par_err) |=> stat_q[ST_PARITY])
    else $error("Parity error flag not set");
  ta_rx_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    own_target_abort_rx |=> stat_q[ST_TA_REC])
    else $error("Received target abort not recorded");
  ta_tx_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    own_target_abort_tx |=> stat_q[ST_TA_SIG])
    else $error("Signalled target abort not recorded");
  ext_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (cfg_req && cfg_addr[7]) |=> cfg_ext_hit && !cfg_hdr_hit)
    else $error("Extension space misdecoded");
  hit_pair_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    cfg_req |=> cfg_ack && (cfg_hdr_hit != cfg_ext_hit))
    else $error("Config access not claimed by one space");
  win_split_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (win_hit && mem_addr[11]) |=> legacy_reg_hit && !sock_reg_hit)
    else $error("Legacy window misdecoded");
  win_miss_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (mem_req && mem_addr[31:BASE_LSB] != base_q) |=> !sock_reg_hit && !legacy_reg_hit)
    else $error("Socket window hit outside its base");

  cfg_read_c: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    rd_was_q && rd_idx_q == IDX_CAPSTAT && cfg_rdata[31]);
  set_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    wr_stat && set_bits[ST_MABORT] && clr_bits[ST_MABORT]);
  sock_hit_c: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    sock_reg_hit ##1 legacy_reg_hit);
  lat_end_c: cover property (@(posedge core_clk) disable iff (!rst_n_q) init_end_req);
endmodule

// ---- cbcfg_host_model.sv ----
// Purpose: Host model issuing configuration cycles to the header slice
// Assumes: One access per call, request held for exactly one clock
// Notes:   Released address and data are inverted so stale values never pass
`timescale 1ns/100ps
module cbcfg_host_model (
  input  wire logic        core_clk,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  input  wire logic        cfg_hdr_hit,
  input  wire logic        cfg_ext_hit
);
  logic [31:0] rd_q;
  logic [2:0]  flags_q;
  initial
  begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'hff;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Answer stands one cycle, so it is taken at the falling edge inside it
  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] wd);
    @(negedge core_clk);
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = wd; // Ones written to flag positions clear them
    @(negedge core_clk);
    rd_q      = cfg_rdata;
    flags_q   = {cfg_ack, cfg_hdr_hit, cfg_ext_hit};
    cfg_req   = 1'b0;
    cfg_addr  = ~a;
    cfg_be    = ~be;
    cfg_wdata = ~wd;
  endtask
endmodule

// ---- cbcfg_header_tb.sv ----
// Purpose: Self-checking bench for the card bridge header slice
// Assumes: Host model drives the config port; bench drives event inputs
// Notes:   Latency expiry is checked at its exact edge; grant-loss end in a window
`timescale 1ns/100ps
module cbcfg_header_tb;
  import cbcfg_pkg::*;
  logic        core_clk, reset_n, cfg_req, cfg_we, mem_req;
  logic [7:0]  cfg_addr, cache_line_size;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr, socket_base;
  logic        cfg_ack, cfg_hdr_hit, cfg_ext_hit, sock_reg_hit, legacy_reg_hit;
  logic        init_frame_start, init_xfer_done, bus_gnt_n, init_lat_expired, init_end_req;
  logic        card_addr_par_err, card_data_par_err, card_serr_n, card_perr_n;
  logic        card_master_dphase, parity_resp_en, own_master_abort;
  logic        own_target_abort_rx, own_target_abort_tx, card_serr_out, card_serr_oe;
  int          fail_count, tests_run, i, j, bits[7];
  logic [15:0] st;
  logic        seen;

  cbcfg_header cbcfg_header_i (.core_clk(core_clk), .reset_n(reset_n), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_hdr_hit(cfg_hdr_hit),
    .cfg_ext_hit(cfg_ext_hit), .mem_req(mem_req), .mem_addr(mem_addr),
    .sock_reg_hit(sock_reg_hit), .legacy_reg_hit(legacy_reg_hit),
    .init_frame_start(init_frame_start), .init_xfer_done(init_xfer_done),
    .bus_gnt_n(bus_gnt_n), .init_lat_expired(init_lat_expired), .init_end_req(init_end_req),
    .card_addr_par_err(card_addr_par_err), .card_data_par_err(card_data_par_err),
    .card_serr_n(card_serr_n), .card_perr_n(card_perr_n),
    .card_master_dphase(card_master_dphase), .parity_resp_en(parity_resp_en),
    .own_master_abort(own_master_abort), .own_target_abort_rx(own_target_abort_rx),
    .own_target_abort_tx(own_target_abort_tx), .card_serr_out(card_serr_out),
    .card_serr_oe(card_serr_oe), .cache_line_size(cache_line_size), .socket_base(socket_base));
  cbcfg_host_model cbcfg_host_model_i (.core_clk(core_clk), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_hdr_hit(cfg_hdr_hit),
    .cfg_ext_hit(cfg_ext_hit));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    cbcfg_host_model_i.access(1'b1, a, be, wd);
    chk1(cbcfg_host_model_i.flags_q[2], 1'b1, "write ack");
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    cbcfg_host_model_i.access(1'b0, a, 4'hf, 32'h0);
    chk32(cbcfg_host_model_i.rd_q, exp, "read data");
    chk32({29'h0, cbcfg_host_model_i.flags_q}, {29'h0, 1'b1, ~a[7], a[7]}, "hits");
  endtask
  task automatic win(input logic [31:0] a, input logic [1:0] exp);
    @(negedge core_clk);
    mem_req  = 1'b1;
    mem_addr = a;
    @(negedge core_clk);
    mem_req  = 1'b0;
    mem_addr = ~a;
    chk32({30'h0, sock_reg_hit, legacy_reg_hit}, {30'h0, exp}, "window");
  endtask
  task automatic evt(input int k);
    @(negedge core_clk);
    case (k)
      0: card_addr_par_err = 1'b1;
      1: card_data_par_err = 1'b1;
      2: card_serr_n = 1'b0;
      3: own_master_abort = 1'b1;
      4: own_target_abort_rx = 1'b1;
      5: own_target_abort_tx = 1'b1;
      default: card_perr_n = 1'b0;
    endcase
    @(negedge core_clk);
    {card_addr_par_err, card_data_par_err, own_master_abort} = 3'h0;
    {own_target_abort_rx, own_target_abort_tx} = 2'h0;
    repeat (3) @(negedge core_clk);
    card_serr_n = 1'b1;
    card_perr_n = 1'b1;
    repeat (5) @(negedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    {reset_n, mem_req, init_frame_start, init_xfer_done, bus_gnt_n} = 5'h0;
    {card_addr_par_err, card_data_par_err, own_master_abort} = 3'h0;
    {own_target_abort_rx, own_target_abort_tx, card_master_dphase} = 3'h0;
    {card_serr_n, card_perr_n, parity_resp_en} = 3'h7;
    mem_addr   = 32'h0;
    fail_count = 0;
    tests_run  = 0;
    bits       = '{15, 15, 14, 13, 12, 11, 8};
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(posedge core_clk);
    cfg_rd(OFF_CACHE_LINE,
           {VAL_SELF_TEST, VAL_HDR_TYPE, RST_LAT_LIMIT, RST_CACHE_LINE});
    cfg_rd(OFF_SOCK_BASE, {RST_SOCK_BASE, 12'h0});
    cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT, 8'h00, VAL_CAP_PTR});
    $display("reset values done");
    cfg_wr(OFF_CACHE_LINE, 4'hf, 32'hffff_ffff);
    cfg_rd(OFF_CACHE_LINE, 32'h0082_ffff);
    cfg_wr(OFF_CACHE_LINE, 4'h1, 32'h0000_005a);
    cfg_rd(OFF_CACHE_LINE, 32'h0082_ff5a);
    chk32({24'h0, cache_line_size}, 32'h5a, "line size port");
    cfg_wr(OFF_CAP_PTR, 4'hf, 32'hffff_ffff);
    cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT, 8'h00, VAL_CAP_PTR});
    $display("byte registers done");
    cfg_wr(OFF_SOCK_BASE, 4'hf, 32'hffff_ffff);
    cfg_rd(OFF_SOCK_BASE, 32'hffff_f000);
    cfg_wr(OFF_SOCK_BASE, 4'hf, 32'h1234_5678);
    cfg_rd(OFF_SOCK_BASE, 32'h1234_5000);
    chk32(socket_base, 32'h1234_5000, "base port");
    win(32'h1234_5004, 2'b10);
    win(32'h1234_5800, 2'b01);
    win(32'h1234_5ffc, 2'b01);
    win(32'h1234_4ffc, 2'b00);
    win(32'h1234_6000, 2'b00);
    cfg_rd(8'h7c, 32'h0);
    cfg_rd(OFF_EXT_FIRST, 32'h0);
    $display("window and decode done");
    card_master_dphase = 1'b1;
    for (i = 0; i < 7; i++)
    begin
      evt(i);
      st = RST_CARD_STAT | (16'h1 << bits[i]);
      cfg_rd(OFF_CAP_PTR, {st, 8'h00, VAL_CAP_PTR});
      cfg_wr(OFF_CAP_PTR, 4'hc, 32'h0);
      cfg_rd(OFF_CAP_PTR, {st, 8'h00, VAL_CAP_PTR});
      cfg_wr(OFF_CAP_PTR, 4'hc, {st, 16'h0});
      cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT, 8'h00, VAL_CAP_PTR});
    end
    for (j = 0; j < 2; j++)
    begin
      {card_master_dphase, parity_resp_en} = j[0] ? 2'b01 : 2'b10;
      evt(6);
      cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT, 8'h00, VAL_CAP_PTR});
    end
    // Event and clearing write in one cycle: the event must win
    fork
      cfg_wr(OFF_CAP_PTR, 4'h8, 32'h2000_0000);
      evt(3);
    join
    cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT | (16'h1 << ST_MABORT), 8'h00, VAL_CAP_PTR});
    cfg_wr(OFF_CAP_PTR, 4'h8, 32'h2000_0000);
    cfg_rd(OFF_CAP_PTR, {RST_CARD_STAT, 8'h00, VAL_CAP_PTR});
    chk32({30'h0, card_serr_out, card_serr_oe}, 32'h0, "serr drive");
    $display("status flags done");
    cfg_wr(OFF_CACHE_LINE, 4'h2, 32'h0000_0600);
    @(negedge core_clk);
    init_frame_start = 1'b1;
    @(negedge core_clk);
    init_frame_start = 1'b0;
    chk1(init_lat_expired, 1'b0, "early expiry");
    repeat (6) @(negedge core_clk);
    chk1(init_lat_expired, 1'b0, "expired before limit");
    @(negedge core_clk);
    chk1(init_lat_expired, 1'b1, "not expired");
    seen = 1'b0;
    repeat (4)
    begin
      @(negedge core_clk);
      seen = seen | init_end_req;
    end
    chk1(seen, 1'b0, "end while granted");
    bus_gnt_n = 1'b1;
    repeat (8)
    begin
      @(negedge core_clk);
      seen = seen | init_end_req;
    end
    chk1(seen, 1'b1, "no end after grant loss");
    init_xfer_done = 1'b1;
    @(negedge core_clk);
    init_xfer_done = 1'b0;
    bus_gnt_n = 1'b0;
    $display("latency done");
    conclude();
  end
endmodule
